//--- urx_addr_rx.sv
// Purpose: Serial receive qualification with framing error and address recognition
// Assumes: baudTick is a one-cycle enable, 16x bit rate in modes 1-3, bit rate in mode 0
// Notes:   Accepted bytes queue in a 32-word FIFO drained by reads of the buffer address
`timescale 1ns/10ps
`include "urx_map.svh"

module urx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] memQ [DEPTH];
  logic [AW-1:0]    wrPtrQ;
  logic [AW-1:0]    rdPtrQ;
  logic [AW:0]      countQ;
  logic             doPush;
  logic             doPop;

  assign inReady  = (countQ != (AW+1)'(DEPTH));
  assign outValid = (countQ != '0);
  assign outData  = memQ[rdPtrQ];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (doPush) begin
      memQ[wrPtrQ] <= inData;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      countQ <= '0;
    end else begin
      if (doPush) begin
        wrPtrQ <= wrPtrQ + 1'b1;
      end
      if (doPop) begin
        rdPtrQ <= rdPtrQ + 1'b1;
      end
      if (doPush && !doPop) begin
        countQ <= countQ + 1'b1;
      end else if (doPop && !doPush) begin
        countQ <= countQ - 1'b1;
      end
    end
  end
endmodule : urx_fifo

module urx_addr_rx (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Baud enable
  input  wire logic             baudTick,
  // Serial line
  input  wire logic             receive_pin,
  // Special function register bus
  input  wire logic [7:0]       sfrAddr,
  input  wire logic             sfrWr,
  input  wire logic             sfrRd,
  input  wire logic [7:0]       sfrWdata,
  output logic      [7:0]       sfrRdata,
  // Status
  output urx_pkg::urx_mode_t    rxMode,
  output logic                  fifoFull
);
  import urx_pkg::*;

  urx_state_e stateQ;
  logic       rxMeta, rxSync, rxPrev;
  logic [3:0] tickQ;
  logic [2:0] bitQ;
  logic [7:0] shiftQ;
  logic       ninthQ;
  logic       modeHiQ, sm1Q, mpEnQ, renQ, tb8Q, rxNinthQ, tiQ, rxDoneQ;
  logic       frameErrQ;
  logic [7:0] pconQ;
  logic [7:0] ownAddrQ;
  logic [7:0] addrMaskQ;
  logic       errSel;
  logic       ctrlWr, bufRd;
  logic       midSample, fallEdge, frameDone;
  logic [7:0] frameByte;
  logic       stopOk, ninthBit, addrMatch, accept;
  logic       fifoInReady, fifoOutValid;
  logic [7:0] fifoOutData;

  assign errSel   = pconQ[`URX_PWR_ERR_SEL];
  assign rxMode   = {modeHiQ, sm1Q};
  assign ctrlWr   = sfrWr && (sfrAddr == `URX_CTRL_ADDR);
  assign bufRd    = sfrRd && (sfrAddr == `URX_BUF_ADDR);
  assign fifoFull = !fifoInReady;

  // Line crosses in from the pin
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
      rxPrev <= 1'b1;
    end else begin
      rxMeta <= receive_pin;
      rxSync <= rxMeta;
      rxPrev <= rxSync;
    end
  end

  assign fallEdge  = rxPrev && !rxSync;
  assign midSample = baudTick && (tickQ == `URX_TICK_MID);

  // Frame ends at mid stop bit, or at the eighth shift clock in mode 0
  assign frameDone = (stateQ == RX_STOP && midSample) ||
                     (stateQ == RX_SHIFT0 && baudTick && bitQ == `URX_LAST_BIT);
  assign frameByte = (stateQ == RX_SHIFT0) ? {rxSync, shiftQ[7:1]} : shiftQ;
  assign stopOk    = (stateQ == RX_SHIFT0) || rxSync;
  assign ninthBit  = (rxMode == 2'b01) ? rxSync : ninthQ;

  assign addrMatch = (((frameByte ^ ownAddrQ) & addrMaskQ) == 8'h00) ||
                     ((((ownAddrQ | addrMaskQ) & ~frameByte)) == 8'h00);

  always_comb begin
    accept = 1'b0;
    if (frameDone && !rxDoneQ && fifoInReady) begin
      case (rxMode)
        2'b00:   accept = 1'b1;
        2'b01:   accept = !mpEnQ || (stopOk && addrMatch);
        default: accept = !mpEnQ || (ninthBit && addrMatch);
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= RX_IDLE;
      tickQ  <= 4'h0;
      bitQ   <= 3'h0;
      shiftQ <= 8'h00;
      ninthQ <= 1'b0;
    end else begin
      if (baudTick) begin
        tickQ <= tickQ + 4'h1;
      end
      case (stateQ)
        RX_IDLE: begin
          bitQ <= 3'h0;
          if (renQ && rxMode == 2'b00 && !rxDoneQ) begin
            stateQ <= RX_SHIFT0;
          end else if (renQ && rxMode != 2'b00 && fallEdge) begin
            tickQ  <= 4'h0;
            stateQ <= RX_START;
          end
        end
        RX_START: begin
          if (midSample) begin
            stateQ <= rxSync ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (midSample) begin
            shiftQ <= {rxSync, shiftQ[7:1]};
            bitQ   <= bitQ + 3'h1;
            if (bitQ == `URX_LAST_BIT) begin
              stateQ <= (rxMode == 2'b01) ? RX_STOP : RX_NINTH;
            end
          end
        end
        RX_NINTH: begin
          if (midSample) begin
            ninthQ <= rxSync;
            stateQ <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (midSample) begin
            stateQ <= RX_IDLE;
          end
        end
        RX_SHIFT0: begin
          if (baudTick) begin
            shiftQ <= {rxSync, shiftQ[7:1]};
            bitQ   <= bitQ + 3'h1;
            if (bitQ == `URX_LAST_BIT) begin
              stateQ <= RX_IDLE;
            end
          end
        end
        default: stateQ <= RX_IDLE;
      endcase
    end
  end

  // Receive buffer queue; a full queue refuses the frame like a set flag
  urx_fifo #(
    .WIDTH(`URX_FIFO_WIDTH),
    .DEPTH(`URX_FIFO_DEPTH)
  ) u_fifo (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .inValid (accept),
    .inReady (fifoInReady),
    .inData  (frameByte),
    .outValid(fifoOutValid),
    .outReady(bufRd),
    .outData (fifoOutData)
  );

  // Control register; hardware set of the flag beats a same-cycle clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {modeHiQ, sm1Q, mpEnQ, renQ, tb8Q, rxNinthQ, tiQ, rxDoneQ} <= `URX_REG_RESET;
    end else begin
      if (ctrlWr) begin
        if (!errSel) begin
          modeHiQ <= sfrWdata[`URX_CTRL_ERR_MODE];
        end
        sm1Q     <= sfrWdata[`URX_CTRL_MODE_LO];
        mpEnQ    <= sfrWdata[`URX_CTRL_MP_EN];
        renQ     <= sfrWdata[`URX_CTRL_RX_EN];
        tb8Q     <= sfrWdata[`URX_CTRL_TX_NINTH];
        rxNinthQ <= sfrWdata[`URX_CTRL_RX_NINTH];
        tiQ      <= sfrWdata[`URX_CTRL_TX_DONE];
        rxDoneQ  <= sfrWdata[`URX_CTRL_RX_DONE];
      end
      if (accept) begin
        rxDoneQ <= 1'b1;
        if (rxMode != 2'b00) begin
          rxNinthQ <= ninthBit;
        end
      end
    end
  end

  // Framing error flag; a fresh error beats a same-cycle clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      frameErrQ <= 1'b0;
    end else begin
      if (frameDone && rxMode != 2'b00 && !stopOk) begin
        frameErrQ <= 1'b1;
      end else if (ctrlWr && errSel) begin
        frameErrQ <= sfrWdata[`URX_CTRL_ERR_MODE];
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ownAddrQ  <= `URX_REG_RESET;
      addrMaskQ <= `URX_REG_RESET;
      pconQ     <= `URX_REG_RESET;
    end else if (sfrWr) begin
      if (sfrAddr == `URX_OWN_ADDR) begin
        ownAddrQ <= sfrWdata;
      end
      if (sfrAddr == `URX_MASK_ADDR) begin
        addrMaskQ <= sfrWdata;
      end
      if (sfrAddr == `URX_PWR_ADDR) begin
        pconQ <= sfrWdata;
      end
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sfrRdata <= 8'h00;
    end else if (sfrRd) begin
      case (sfrAddr)
        `URX_CTRL_ADDR:  sfrRdata <= {errSel ? frameErrQ : modeHiQ, sm1Q, mpEnQ, renQ,
                                      tb8Q, rxNinthQ, tiQ, rxDoneQ};
        `URX_BUF_ADDR:   sfrRdata <= fifoOutValid ? fifoOutData : 8'h00;
        `URX_PWR_ADDR:   sfrRdata <= pconQ;
        `URX_OWN_ADDR:   sfrRdata <= ownAddrQ;
        `URX_MASK_ADDR:  sfrRdata <= addrMaskQ;
        default:         sfrRdata <= 8'h00;
      endcase
    end
  end

  property p_fe_set;
    @(posedge mclk) disable iff (sys_rst)
      (frameDone && rxMode != 2'b00 && !rxSync) |=> frameErrQ;
  endproperty
  a_fe_set: assert property (p_fe_set) else $error("frame error not flagged");

  property p_fe_mode0;
    @(posedge mclk) disable iff (sys_rst)
      (rxMode == 2'b00 && !frameErrQ && !ctrlWr) |=> !frameErrQ;
  endproperty
  a_fe_mode0: assert property (p_fe_mode0) else $error("frame error in mode 0");

  property p_shared_read;
    @(posedge mclk) disable iff (sys_rst)
      (sfrRd && sfrAddr == `URX_CTRL_ADDR) |=>
        sfrRdata[7] == ($past(errSel) ? $past(frameErrQ) : $past(modeHiQ));
  endproperty
  a_shared_read: assert property (p_shared_read) else $error("shared bit wrong");

  property p_sep_store;
    @(posedge mclk) disable iff (sys_rst)
      (ctrlWr && errSel) |=> $stable(modeHiQ);
  endproperty
  a_sep_store: assert property (p_sep_store) else $error("mode bit disturbed");

  property p_fe_sticky;
    @(posedge mclk) disable iff (sys_rst)
      (frameErrQ && !(ctrlWr && errSel)) |=> frameErrQ;
  endproperty
  a_fe_sticky: assert property (p_fe_sticky) else $error("frame error lost");

  property p_ninth_zero;
    @(posedge mclk) disable iff (sys_rst)
      (frameDone && rxMode[1] && mpEnQ && !ninthQ && !rxDoneQ && !ctrlWr) |=> !rxDoneQ;
  endproperty
  a_ninth_zero: assert property (p_ninth_zero) else $error("data frame flagged");

  property p_mode1_stop;
    @(posedge mclk) disable iff (sys_rst)
      (frameDone && rxMode == 2'b01 && mpEnQ && !rxSync && !rxDoneQ && !ctrlWr)
        |=> !rxDoneQ;
  endproperty
  a_mode1_stop: assert property (p_mode1_stop) else $error("bad stop flagged");

  property p_addr_miss;
    @(posedge mclk) disable iff (sys_rst)
      (frameDone && rxMode != 2'b00 && mpEnQ && !addrMatch && !rxDoneQ && !ctrlWr)
        |=> !rxDoneQ;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address flagged");

  property p_accept_load;
    @(posedge mclk) disable iff (sys_rst)
      (accept && rxMode != 2'b00) |=> (rxDoneQ && rxNinthQ == $past(ninthBit));
  endproperty
  a_accept_load: assert property (p_accept_load) else $error("accept not loaded");

  property p_idle_after;
    @(posedge mclk) disable iff (sys_rst)
      frameDone |=> (stateQ == RX_IDLE);
  endproperty
  a_idle_after: assert property (p_idle_after) else $error("no return to idle");

endmodule : urx_addr_rx

//--- urx_map.svh
// Purpose: Addresses, bit positions and counts for the receive qualifier
// Assumes: 8-bit special function register bus, 16x oversampling tick
// Notes:   Definitions only
`ifndef URX_MAP_SVH
`define URX_MAP_SVH

`define URX_CTRL_ADDR      8'hD8
`define URX_BUF_ADDR       8'hD9
`define URX_PWR_ADDR       8'hDA
`define URX_OWN_ADDR       8'hA9
`define URX_MASK_ADDR      8'hB9

`define URX_CTRL_ERR_MODE  7
`define URX_CTRL_MODE_LO   6
`define URX_CTRL_MP_EN     5
`define URX_CTRL_RX_EN     4
`define URX_CTRL_TX_NINTH  3
`define URX_CTRL_RX_NINTH  2
`define URX_CTRL_TX_DONE   1
`define URX_CTRL_RX_DONE   0
`define URX_PWR_ERR_SEL    6

`define URX_REG_RESET    8'h00
`define URX_TICK_MID     4'h7
`define URX_LAST_BIT     3'h7
`define URX_FIFO_WIDTH   8
`define URX_FIFO_DEPTH   32

`endif

//--- urx_pkg.sv
// Purpose: Types for the receive qualifier
// Assumes: Nothing beyond the map header
// Notes:   Constants live in urx_map.svh
package urx_pkg;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_NINTH,
    RX_STOP,
    RX_SHIFT0
  } urx_state_e;

  typedef logic [1:0] urx_mode_t;

endpackage : urx_pkg

//--- urx_station.sv
// Purpose: Far serial station driving the receive line
// Assumes: Sixteen baud ticks per bit, idle level high
// Notes:   Line returns high after every frame
`timescale 1ns/10ps
module urx_station (
  // Clock and tick
  input  wire logic mclk,
  input  wire logic baudTick,
  // Serial line
  output logic      rxLine
);
  initial rxLine = 1'b1;

  task automatic holdBit(input logic b);
    rxLine = b;
    repeat (16) @(posedge mclk iff baudTick);
    #1;
  endtask : holdBit

  task automatic sendFrame(input logic [7:0] d, input logic hasNinth,
                           input logic ninth, input logic stopBit);
    holdBit(1'b0);
    for (int i = 0; i < 8; i++) begin
      holdBit(d[i]);
    end
    if (hasNinth) begin
      holdBit(ninth);
    end
    holdBit(stopBit);
    rxLine = 1'b1;
  endtask : sendFrame
endmodule : urx_station

//--- testbench.sv
// Purpose: Register level test of the receive qualifier
// Assumes: Baud tick every second clock
// Notes:   Mode 0 with an idle line gives 0xFF bytes, used to fill the FIFO fast
`timescale 1ns/10ps
`include "urx_map.svh"
module testbench;
  import urx_pkg::*;
  localparam logic [7:0] ACTL = `URX_CTRL_ADDR;
  localparam logic [7:0] ABUF = `URX_BUF_ADDR;
  localparam logic [7:0] APWR = `URX_PWR_ADDR;
  localparam logic [7:0] AOWN = `URX_OWN_ADDR;
  localparam logic [7:0] AMSK = `URX_MASK_ADDR;
  logic       mclk, sys_rst, baudTick, rxLine, sfrWr, sfrRd, fifoFull;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata;
  urx_mode_t  rxMode;
  int         error_cnt, n_checks, cycles;
  logic [7:0] aByte [5] = '{8'hC0, 8'hC2, 8'hC1, 8'hFF, 8'hC0};
  logic       aNinth [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic       aHit [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  urx_addr_rx uut (.mclk(mclk), .sys_rst(sys_rst), .baudTick(baudTick),
    .receive_pin(rxLine), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .rxMode(rxMode), .fifoFull(fifoFull));
  urx_station uStation (.mclk(mclk), .baudTick(baudTick), .rxLine(rxLine));

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    #1;
    baudTick = ~baudTick;
  end
  // Hang guard, far above the expected run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWdata = d;
    sfrWr = 1'b1;
    tick(1);
    sfrWr = 1'b0;
    tick(1);
  endtask : wr

  // Masked compare of a register read
  task automatic rdChk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    sfrAddr = a;
    sfrRd = 1'b1;
    tick(1);
    sfrRd = 1'b0;
    tick(1);
    chk(sfrRdata & m, exp);
  endtask : rdChk

  task automatic send(input logic [7:0] d, input logic hn, input logic n, input logic s);
    uStation.sendFrame(d, hn, n, s);
    tick(4);
  endtask : send

  task automatic end_of_test;
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  initial begin
    sys_rst = 1'b1;
    baudTick = 1'b0;
    sfrAddr = 8'h00;
    sfrWdata = 8'h00;
    sfrWr = 1'b0;
    sfrRd = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    cycles = 0;
    tick(3);
    sys_rst = 1'b0;
    rdChk(AOWN, 8'hFF, 8'h00);
    rdChk(AMSK, 8'hFF, 8'h00);
    rdChk(ACTL, 8'hFF, 8'h00);
    rdChk(8'h10, 8'hFF, 8'h00);
    wr(AOWN, 8'hC0);
    wr(AMSK, 8'hFD);
    rdChk(AOWN, 8'hFF, 8'hC0);
    rdChk(AMSK, 8'hFF, 8'hFD);
    // Second frame lands while the flag is still set
    wr(ACTL, 8'h90);
    send(8'h35, 1'b1, 1'b0, 1'b1);
    send(8'hA6, 1'b1, 1'b1, 1'b1);
    rdChk(ACTL, 8'h05, 8'h01);
    chk({6'h00, rxMode}, 8'h02);
    rdChk(ABUF, 8'hFF, 8'h35);
    rdChk(ABUF, 8'hFF, 8'h00);
    // Given C0 with bit 1 free, broadcast FD with bit 1 free
    // enable set on slave
    for (int k = 0; k < 5; k++) begin
      wr(ACTL, 8'hF0);
      send(aByte[k], 1'b1, aNinth[k], 1'b1);
      rdChk(ACTL, 8'h05, {5'h00, aHit[k], 1'b0, aHit[k]});
      if (aHit[k]) begin
        rdChk(ABUF, 8'hFF, aByte[k]);
      end
    end
    wr(ACTL, 8'hD0);
    send(8'h5A, 1'b1, 1'b0, 1'b1);
    rdChk(ACTL, 8'h05, 8'h01);
    rdChk(ABUF, 8'hFF, 8'h5A);
    wr(ACTL, 8'hF0);
    send(8'h5A, 1'b1, 1'b0, 1'b1);
    rdChk(ACTL, 8'h01, 8'h00);
    // Mode 1, stop bit stands in for the ninth
    wr(ACTL, 8'h70);
    send(8'hC2, 1'b0, 1'b0, 1'b1);
    rdChk(ACTL, 8'h05, 8'h05);
    rdChk(ABUF, 8'hFF, 8'hC2);
    wr(ACTL, 8'h70);
    send(8'hC2, 1'b0, 1'b0, 1'b0);
    rdChk(ACTL, 8'h01, 8'h00);
    send(8'h55, 1'b0, 1'b0, 1'b1);
    rdChk(ACTL, 8'h01, 8'h00);
    wr(APWR, 8'h40);
    rdChk(ACTL, 8'h80, 8'h80);
    wr(APWR, 8'h00);
    rdChk(ACTL, 8'h80, 8'h00);
    wr(ACTL, 8'h50);
    send(8'h33, 1'b0, 1'b0, 1'b1);
    wr(APWR, 8'h40);
    rdChk(ACTL, 8'h81, 8'h81);
    rdChk(ABUF, 8'hFF, 8'h33);
    wr(ACTL, 8'h50);
    rdChk(ACTL, 8'h80, 8'h00);
    wr(APWR, 8'h00);
    wr(ACTL, 8'hD0);
    chk({6'h00, rxMode}, 8'h03);
    wr(APWR, 8'h40);
    rdChk(ACTL, 8'h80, 8'h00);
    wr(APWR, 8'h00);
    rdChk(ACTL, 8'h80, 8'h80);
    // Mode 0 ignores multiproc enable and framing
    wr(ACTL, 8'h30);
    tick(40);
    rdChk(ACTL, 8'h01, 8'h01);
    rdChk(ABUF, 8'hFF, 8'hFF);
    wr(APWR, 8'h40);
    rdChk(ACTL, 8'h80, 8'h00);
    wr(APWR, 8'h00);
    // Fill the FIFO until it refuses, then drain it
    for (int k = 0; k < 33; k++) begin
      wr(ACTL, 8'h30);
      tick(40);
    end
    chk({7'h00, fifoFull}, 8'h01);
    rdChk(ACTL, 8'h01, 8'h00);
    wr(ACTL, 8'h00);
    // Let a shift already under way finish while the queue still refuses it
    tick(40);
    for (int k = 0; k < 32; k++) begin
      rdChk(ABUF, 8'hFF, 8'hFF);
    end
    chk({7'h00, fifoFull}, 8'h00);
    rdChk(ABUF, 8'hFF, 8'h00);
    end_of_test();
  end
endmodule : testbench
